/* File: rtl/quad_dac_update_sequencer.sv */
// Update sequencer for a four-channel 16-bit DAC on a serial link with load line.
// Assumes channel words and range choices come from logic on the same clock.
`timescale 1ns/1ps
module quad_dac_update_sequencer
  import dac_seq_pkg::*;
#(
  parameter int CLK_HZ = SYS_CLK_HZ
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  input  wire logic       i_fixed_rate,
  input  wire dac_set_t   i_set,
  input  wire range_cfg_t i_range,
  output dac_link_t       o_link,
  output logic            o_frame_start,
  output logic            o_busy
);

  // ****************************************************************
  // Derived cycle counts
  // ****************************************************************
  localparam int         BIT_CYC    = CLK_HZ / SCLK_MAX_HZ + 1;
  localparam int         LOAD_RAW   = (LOAD_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int         LOAD_CYC   = (LOAD_RAW < 1) ? 1 : LOAD_RAW;
  localparam int         PERIOD_CYC = CLK_HZ / FIXED_RATE_HZ;
  localparam logic [7:0] LOAD_M1    = 8'(LOAD_CYC - 1);
  localparam logic [15:0] PER_M1    = 16'(PERIOD_CYC - 1);
  localparam logic [1:0] CH_LAST    = 2'(NUM_CH - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_LOAD = 3'b100
  } seq_state_t;

  seq_state_t                state_q, state_d;
  logic [1:0]                ch_q, ch_d;
  logic                      cfg_q, cfg_d;
  logic                      init_q, init_d;
  dac_set_t                  set_q, set_d;
  range_cfg_t                rng_q, rng_d;
  logic [15:0]               rate_q, rate_d;
  logic                      pend_q, pend_d;
  logic [7:0]                lcnt_q, lcnt_d;
  logic                      start;
  logic                      start_data;
  logic                      last;
  logic                      go;
  logic                      launch;
  logic                      rng_dirty;
  logic                      tick;
  logic [BITS_PER_FRAME-1:0] word;

  // Translate a range selection into the register code
  function automatic logic [2:0] rng_code(input range_sel_t s);
    logic [2:0] c;
    c = RNG_CODE_U5;
    unique case (s)
      RNG_U5:  c = RNG_CODE_U5;
      RNG_U10: c = RNG_CODE_U10;
      RNG_B5:  c = RNG_CODE_B5;
      RNG_B10: c = RNG_CODE_B10;
    endcase
    return c;
  endfunction

  // ****************************************************************
  // Update pacing
  // ****************************************************************
  // Fixed workflow: one tick per period; the period is CLK_HZ over 50 kHz
  assign tick      = (rate_q == PER_M1);
  assign rng_dirty = init_q || (i_range != rng_q);
  assign go        = i_fixed_rate ? pend_q : 1'b1;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state for batches of four frames and the load strobe
  always_comb begin
    state_d    = state_q;
    ch_d       = ch_q;
    cfg_d      = cfg_q;
    init_d     = init_q;
    set_d      = set_q;
    rng_d      = rng_q;
    lcnt_d     = lcnt_q;
    start      = 1'b0;
    start_data = 1'b0;
    launch     = 1'b0;
    rate_d     = tick ? 16'h0000 : rate_q + 16'h0001;
    unique case (state_q)
      ST_IDLE: begin
        launch = 1'b1;
      end
      ST_SEND: begin
        if (last) begin
          if (ch_q == CH_LAST) begin
            if (cfg_q) begin
              state_d = ST_IDLE;
            end else begin
              state_d = ST_LOAD;
              lcnt_d  = 8'h00;
            end
          end else begin
            start = 1'b1;
            ch_d  = ch_q + 2'h1;
          end
        end
      end
      ST_LOAD: begin
        if (lcnt_q == LOAD_M1) begin
          state_d = ST_IDLE;
          launch  = 1'b1;
        end else begin
          lcnt_d = lcnt_q + 8'h01;
        end
      end
    endcase
    // Launch from idle or in the last load cycle: period is frames plus load
    if (launch && rng_dirty) begin
      start   = 1'b1;
      cfg_d   = 1'b1;
      ch_d    = 2'h0;
      rng_d   = i_range;
      init_d  = 1'b0;
      state_d = ST_SEND;
    end else if (launch && go) begin
      start      = 1'b1;
      start_data = 1'b1;
      cfg_d      = 1'b0;
      ch_d       = 2'h0;
      set_d      = i_set;
      state_d    = ST_SEND;
    end
    // A tick in the same cycle as the start is kept: set wins over clear
    pend_d = tick || (pend_q && !start_data);
  end

  // Build the frame for the channel being started
  always_comb begin
    word                               = '0;
    word[FR_RW_BIT]                    = 1'b0;
    word[FR_CH_LSB +: 3]               = {1'b0, ch_d};
    if (cfg_d) begin
      word[FR_REG_LSB +: 3] = REG_RANGE;
      word[2:0]             = rng_code(rng_d.ch[ch_d]);
    end else begin
      word[FR_REG_LSB +: 3] = REG_DAC;
      word[DATA_W-1:0]      = set_d.ch[ch_d];
    end
  end

  // Register the sequencer state
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      ch_q    <= 2'h0;
      cfg_q   <= 1'b0;
      init_q  <= 1'b1;
      set_q   <= '0;
      rng_q   <= '0;
      rate_q  <= 16'h0000;
      pend_q  <= 1'b0;
      lcnt_q  <= 8'h00;
    end else begin
      state_q <= state_d;
      ch_q    <= ch_d;
      cfg_q   <= cfg_d;
      init_q  <= init_d;
      set_q   <= set_d;
      rng_q   <= rng_d;
      rate_q  <= rate_d;
      pend_q  <= pend_d;
      lcnt_q  <= lcnt_d;
    end
  end

  dac_word_shifter #(
    .BIT_CYC (BIT_CYC)
  ) u_shifter (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_start   (start),
    .i_word    (word),
    .o_sclk    (o_link.sclk),
    .o_sdo     (o_link.sdo),
    .o_sync_n  (o_link.sync_n),
    .o_last    (last)
  );

  // Load strobe low exactly while in the load state
  assign o_link.load_n = (state_q != ST_LOAD);
  assign o_busy        = (state_q != ST_IDLE);
  assign o_frame_start = start_data;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  logic [2:0]  dcnt_q;
  logic [15:0] since_q;
  logic        clean_q;
  logic        tick_q;
  logic        paced_q;
  logic [7:0]  lw_q;

  // Helpers: data frames per batch, cycles between starts, no config in between
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      dcnt_q  <= 3'h0;
      since_q <= 16'h0000;
      clean_q <= 1'b0;
      tick_q  <= 1'b0;
      paced_q <= 1'b0;
      lw_q    <= 8'h00;
    end else begin
      if (start_data) begin
        dcnt_q <= 3'h0;
      end else if (last && !cfg_q) begin
        dcnt_q <= dcnt_q + 3'h1;
      end
      since_q <= start_data ? 16'h0001 : since_q + 16'h0001;
      clean_q <= start_data ? 1'b1 : (clean_q && !(start && !start_data && cfg_d));
      // Previous batch started right after a tick in fixed mode
      tick_q  <= tick;
      paced_q <= start_data ? (i_fixed_rate && tick_q) : paced_q;
      // Length of the current load strobe
      lw_q    <= o_link.load_n ? 8'h00 : lw_q + 8'h01;
    end
  end

  a_load_order: assert property ($fell(o_link.load_n) |->
    $past(state_q) == ST_SEND && $past(ch_q) == CH_LAST && !$past(cfg_q))
    else $error("load strobe not right after fourth channel");

  a_all_four: assert property (state_q == ST_LOAD |-> dcnt_q == 3'h4)
    else $error("load without four data frames");

  a_load_width: assert property ($rose(o_link.load_n) |->
    lw_q == LOAD_M1 + 8'h01)
    else $error("load strobe width wrong");

  a_no_cfg_load: assert property (cfg_q && state_q == ST_SEND |=> o_link.load_n)
    else $error("load strobe after range frames");

  a_cfg_first: assert property (o_frame_start |-> !init_q)
    else $error("data batch before range setup");

  a_fixed_rate: assert property (i_fixed_rate && o_frame_start &&
    $past(i_fixed_rate, 1) && tick_q && paced_q && clean_q && since_q < 16'hFFFF |->
    since_q == 16'(PERIOD_CYC))
    else $error("fixed update period wrong");

  a_latch_hold: assert property (!start_data |=> $stable(set_q))
    else $error("channel set changed outside batch start");

  c_cfg_batch:  cover property (cfg_q && last && ch_q == CH_LAST);
  c_load_pulse: cover property ($rose(o_link.load_n));
  c_fixed_two:  cover property (i_fixed_rate && o_frame_start && tick_q && paced_q);

endmodule

/* File: include/dac_seq_pkg.sv */
// Shared constants and types for the four-channel DAC update sequencer.
// Assumes a single user logic clock; all cycle counts derive from its rate.
package dac_seq_pkg;

  // ****************************************************************
  // Link and frame constants
  // ****************************************************************
  localparam int NUM_CH         = 4;           // DAC channels per update
  localparam int DATA_W         = 16;          // Channel word width
  localparam int BITS_PER_FRAME = 24;          // Serial bits per channel frame
  localparam int SCLK_MAX_HZ    = 30_000_000;  // Maximum serial clock rate
  localparam int LOAD_NS        = 200;         // Load strobe time in ns
  localparam int FIXED_RATE_HZ  = 50_000;      // Fixed-workflow update rate
  localparam int FIXED_CLK_HZ   = 75_000_000;  // Fixed-workflow logic clock
  localparam int SYS_CLK_HZ     = 200_000_000; // Default logic clock

  // Frame field positions and register selects
  localparam int         FR_RW_BIT  = 23;
  localparam int         FR_REG_LSB = 19;
  localparam int         FR_CH_LSB  = 16;
  localparam logic [2:0] REG_DAC    = 3'h0;
  localparam logic [2:0] REG_RANGE  = 3'h1;

  // Range codes written into the range registers
  localparam logic [2:0] RNG_CODE_U5  = 3'h0;
  localparam logic [2:0] RNG_CODE_U10 = 3'h1;
  localparam logic [2:0] RNG_CODE_B5  = 3'h3;
  localparam logic [2:0] RNG_CODE_B10 = 3'h4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    RNG_U5  = 2'h0,
    RNG_U10 = 2'h1,
    RNG_B5  = 2'h2,
    RNG_B10 = 2'h3
  } range_sel_t;

  typedef struct packed {
    logic [NUM_CH-1:0][DATA_W-1:0] ch;
  } dac_set_t;

  typedef struct packed {
    range_sel_t [NUM_CH-1:0] ch;
  } range_cfg_t;

  typedef struct packed {
    logic sclk;
    logic sdo;
    logic sync_n;
    logic load_n;
  } dac_link_t;

endpackage

/* File: rtl/dac_word_shifter.sv */
// Serial shifter for one 24-bit frame toward the DAC.
// Assumes BIT_CYC of at least 3 so the select can rise after the last falling edge.
`timescale 1ns/1ps
module dac_word_shifter
  import dac_seq_pkg::*;
#(
  parameter int BIT_CYC = 7
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_start,
  input  wire logic [BITS_PER_FRAME-1:0] i_word,
  output logic                           o_sclk,
  output logic                           o_sdo,
  output logic                           o_sync_n,
  output logic                           o_last
);

  localparam int             CW       = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0]  HALF     = CW'(BIT_CYC / 2);
  localparam logic [CW-1:0]  CYC_LAST = CW'(BIT_CYC - 1);
  localparam logic [4:0]     BIT_LAST = 5'(BITS_PER_FRAME - 1);

  logic                      busy_q, busy_d;
  logic [BITS_PER_FRAME-1:0] sh_q, sh_d;
  logic [4:0]                bit_q, bit_d;
  logic [CW-1:0]             cyc_q, cyc_d;
  logic                      sclk_q, sclk_d;
  logic                      sync_n_q, sync_n_d;

  // ****************************************************************
  // Bit timing and shifting
  // ****************************************************************
  // Last cycle of the last bit; a new start may load in that same cycle
  assign o_last = busy_q && (bit_q == BIT_LAST) && (cyc_q == CYC_LAST);

  // Next state: clock high for the first half of each bit, data changes on rise
  always_comb begin
    busy_d = busy_q;
    sh_d   = sh_q;
    bit_d  = bit_q;
    cyc_d  = cyc_q;
    if (i_start) begin
      busy_d = 1'b1;
      sh_d   = i_word;
      bit_d  = 5'h00;
      cyc_d  = '0;
    end else if (busy_q) begin
      if (cyc_q == CYC_LAST) begin
        cyc_d = '0;
        if (bit_q == BIT_LAST) begin
          busy_d = 1'b0;
        end else begin
          bit_d = bit_q + 5'h01;
          sh_d  = {sh_q[BITS_PER_FRAME-2:0], 1'b0};
        end
      end else begin
        cyc_d = cyc_q + CW'(1);
      end
    end
    sclk_d   = busy_d && (cyc_d < HALF);
    sync_n_d = !(busy_d && !((bit_d == BIT_LAST) && (cyc_d == CYC_LAST)));
  end

  // Register the shifter state
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      busy_q   <= 1'b0;
      sh_q     <= '0;
      bit_q    <= 5'h00;
      cyc_q    <= '0;
      sclk_q   <= 1'b0;
      sync_n_q <= 1'b1;
    end else begin
      busy_q   <= busy_d;
      sh_q     <= sh_d;
      bit_q    <= bit_d;
      cyc_q    <= cyc_d;
      sclk_q   <= sclk_d;
      sync_n_q <= sync_n_d;
    end
  end

  assign o_sclk   = sclk_q;
  assign o_sdo    = sh_q[BITS_PER_FRAME-1];
  assign o_sync_n = sync_n_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [15:0] low_len_q;
  logic [15:0] hi_len_q;

  // Helper counters for select-low and clock-high lengths
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      low_len_q <= 16'h0000;
      hi_len_q  <= 16'h0000;
    end else begin
      low_len_q <= o_sync_n ? 16'h0000 : low_len_q + 16'h0001;
      hi_len_q  <= o_sclk ? hi_len_q + 16'h0001 : 16'h0000;
    end
  end

  a_frame_len: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $rose(o_sync_n) |-> low_len_q == 16'(BITS_PER_FRAME * BIT_CYC - 1))
    else $error("select low length differs from one frame");

  a_sclk_high: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    $fell(o_sclk) |-> hi_len_q == 16'(BIT_CYC / 2))
    else $error("serial clock high time wrong");

endmodule

/* File: tb/dac_link_model.sv */
// Behavioural receiver standing in for the four-channel DAC on the serial link.
// Assumes the select idles high, data is taken on the falling serial clock.
`timescale 1ns/1ps
module dac_link_model
  import dac_seq_pkg::*;
(
  input  wire dac_link_t         i_link,
  output dac_set_t               o_out,
  output logic [NUM_CH-1:0][2:0] o_code,
  output int                     o_rframes,
  output int                     o_loads,
  output int                     o_bad
);
  logic [BITS_PER_FRAME-1:0] shift;
  dac_set_t                  staged;
  int                        nbits;
  int                        next_ch;

  // ****************************************************************
  // Frame capture and decode
  // ****************************************************************
  // Start empty, as a freshly powered converter would
  initial begin
    {o_out, o_code, staged, shift} = '0;
    {o_rframes, o_loads, o_bad, nbits, next_ch} = '0;
  end

  // Shift one bit on each falling serial clock while selected
  always @(negedge i_link.sclk) begin
    if (!i_link.sync_n) begin
      shift = {shift[BITS_PER_FRAME-2:0], i_link.sdo};
      nbits++;
    end
  end

  // A whole frame is judged when the select rises
  always @(posedge i_link.sync_n) begin
    if (nbits != 0) begin
      if (nbits != BITS_PER_FRAME || shift[23:22] != 2'h0 || shift[18]) begin
        o_bad++;
      end else if (shift[21:19] == REG_RANGE) begin
        o_code[shift[17:16]] = shift[2:0];
        o_rframes++;
      end else if (shift[21:19] == REG_DAC && int'(shift[17:16]) == next_ch) begin
        staged.ch[shift[17:16]] = shift[15:0];
        next_ch++;
      end else begin
        o_bad++;
      end
    end
    nbits = 0;
  end

  // Load applies all staged words at once; needs all four channels first
  always @(negedge i_link.load_n) begin
    if (next_ch != NUM_CH) begin
      o_bad++;
    end
    o_out = staged;
    o_loads++;
    next_ch = 0;
  end
endmodule

/* File: tb/quad_dac_update_sequencer_test.sv */
// Self-checking bench for the four-channel DAC update sequencer.
// Assumes the block is set for 75 MHz through CLK_HZ so that counts stay short; the bench clock itself runs at 200 MHz.
`timescale 1ns/1ps
module quad_dac_update_sequencer_test;
  import dac_seq_pkg::*;
  localparam int CLK    = 75_000_000;
  localparam int BIT    = CLK / SCLK_MAX_HZ + 1;
  localparam int LOAD   = LOAD_NS * (CLK / 1_000_000) / 1000;
  localparam int PERIOD = NUM_CH * BITS_PER_FRAME * BIT + LOAD;
  localparam int TICK   = CLK / FIXED_RATE_HZ;
  logic                   clk;
  logic                   rst;
  logic                   fixed;
  dac_set_t               set;
  range_cfg_t             rng;
  dac_link_t              link;
  logic                   fstart;
  logic                   busy;
  dac_set_t               out;
  logic [NUM_CH-1:0][2:0] code;
  int                     rframes;
  int                     loads;
  int                     bad;
  int                     mismatches = 0;
  int                     checks = 0;
  int                     cyc = 0;
  int                     load_run = 0;
  int                     load_len = 0;
  int                     sync_run = 0;
  int                     sync_len = 0;
  int                     sclk_t = 0;
  int                     bit_len = 0;
  logic                   sclk_prev = 1'b0;

  quad_dac_update_sequencer #(.CLK_HZ(CLK)) i_dut (
    .i_clk_sys    (clk),
    .i_sys_rst    (rst),
    .i_fixed_rate (fixed),
    .i_set        (set),
    .i_range      (rng),
    .o_link       (link),
    .o_frame_start(fstart),
    .o_busy       (busy)
  );

  dac_link_model i_dac (
    .i_link   (link),
    .o_out    (out),
    .o_code   (code),
    .o_rframes(rframes),
    .o_loads  (loads),
    .o_bad    (bad)
  );

  // ****************************************************************
  // Clock, cycle count and link timing monitor
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // Measure load width, select width and serial bit length
  always @(negedge clk) begin
    if (link.load_n === 1'b0) begin
      load_run++;
    end else if (load_run > 0) begin
      load_len = load_run;
      load_run = 0;
    end
    if (link.sync_n === 1'b0) begin
      sync_run++;
    end else if (sync_run > 0) begin
      sync_len = sync_run;
      sync_run = 0;
    end
    if (link.sclk === 1'b1 && sclk_prev === 1'b0) begin
      bit_len = cyc - sclk_t;
      sclk_t  = cyc;
    end
    sclk_prev = link.sclk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  function automatic logic [2:0] code_of(input range_sel_t r);
    case (r)
      RNG_U5:  return RNG_CODE_U5;
      RNG_U10: return RNG_CODE_U10;
      RNG_B5:  return RNG_CODE_B5;
      default: return RNG_CODE_B10;
    endcase
  endfunction

  // Wait for a batch start pulse, giving up after a bounded time
  task automatic wait_start(output int t);
    t = -1;
    for (int i = 0; i < 4000; i++) begin
      @(negedge clk);
      if (fstart === 1'b1) begin
        t = cyc;
        break;
      end
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    @(negedge clk);
    chk("sync_n in reset", 1, link.sync_n);
    chk("load_n in reset", 1, link.load_n);
    chk("sclk in reset", 0, link.sclk);
    chk("busy in reset", 0, busy);
    $display("test reset done");
  endtask

  task automatic t_ranges(input range_cfg_t r, input int n);
    @(posedge clk);
    rng <= r;
    for (int i = 0; i < 3000 && rframes < n; i++) @(negedge clk);
    chk("range frames", n, rframes);
    for (int i = 0; i < NUM_CH; i++) chk("range code", code_of(r.ch[i]), code[i]);
    $display("test ranges done");
  endtask

  task automatic t_data();
    int       t0;
    int       t1;
    dac_set_t a;
    dac_set_t b;
    a.ch = {16'hF00D, 16'h8001, 16'h7FFE, 16'h1234};
    b.ch = ~a.ch;
    @(posedge clk);
    set <= a;
    wait_start(t0);
    wait_start(t0);
    @(posedge clk);
    set <= b;
    wait_start(t1);
    // Let the load end and two bits of the new frame pass before measuring
    repeat (2 * BIT + 2) @(negedge clk);
    chk("update period", PERIOD, t1 - t0);
    chk("load width", LOAD, load_len);
    chk("select width", BITS_PER_FRAME * BIT - 1, sync_len);
    chk("bit length", BIT, bit_len);
    for (int i = 0; i < NUM_CH; i++) chk("first output", a.ch[i], out.ch[i]);
    wait_start(t0);
    for (int i = 0; i < NUM_CH; i++) chk("second output", b.ch[i], out.ch[i]);
    $display("test data done");
  endtask

  task automatic t_fixed();
    int t0;
    int t1;
    @(posedge clk);
    fixed <= 1'b1;
    wait_start(t0);
    wait_start(t0);
    wait_start(t1);
    chk("fixed spacing", TICK, t1 - t0);
    chk("link faults", 0, bad);
    $display("test fixed done");
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    range_cfg_t r1;
    range_cfg_t r2;
    for (int i = 0; i < NUM_CH; i++) begin
      r1.ch[i] = range_sel_t'(i[1:0]);
      r2.ch[i] = range_sel_t'(2'(i + 1));
    end
    rst   = 1'b1;
    fixed = 1'b0;
    set   = '0;
    rng   = r1;
    t_reset();
    @(posedge clk);
    rst <= 1'b0;
    t_ranges(r1, 4);
    t_data();
    t_ranges(r2, 8);
    t_fixed();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("MISMATCH watchdog expected finish seen hang");
    conclude();
  end
endmodule
